//--- core/swc_clock_control.sv
`include "swc_defs.svh"

// sys_clk stands for the oscillator; osc_run_en gates the real resonator.
module swc_clock_control
  import swc_pkg::*;
#(
  parameter int PW = 8
) (
  // Clock and reset
  input  wire logic          sys_clk,
  input  wire logic          arst_n,
  // Core requests
  input  wire logic          stop_instruction,
  input  wire logic          wait_instruction,
  input  wire logic          irq_accepted,
  // Clock outputs
  output logic               phi_out,
  output logic               osc_run_en,
  output logic               stab_route,
  // Observation of prescaler and timer
  output logic [PW-1:0]      prescaler_val,
  output logic [PW-1:0]      timer_val,
  output logic               timer_overflow
);
  import swc_pkg::*;

  // State and divider registers
  swc_state_t    state_reg;
  swc_state_t    state_next;
  logic [1:0]    phase_reg;
  logic [1:0]    phase_next;
  logic [3:0]    pre16_reg;
  logic [3:0]    pre16_next;
  logic          route_reg;
  logic          route_next;
  logic          phi_reg;
  logic          phi_next;
  logic          osc_reg;
  logic          osc_next;
  logic          ovf_reg;
  logic          ovf_next;

  // Prescaler and timer taps
  logic [PW-1:0] pre_cnt;
  logic [PW-1:0] tmr_cnt;
  logic          pre_uf;
  logic          tmr_uf;

  // State decode
  logic          in_run;
  logic          in_stop;
  logic          in_settle;
  logic          in_wait;
  logic          run_next;

  // Core request qualification
  logic          do_stop;
  logic          do_wait;
  logic          wake_stop;
  logic          wake_wait;
  logic          settle_done;

  // Stabilisation chain control
  logic          osc_live;
  logic          pre16_run;
  logic          div16_wrap;
  logic          div16_tick;
  logic          route_set;
  logic          route_clr;

  // One-hot decode of the current and next state
  assign in_run    = (state_reg == SWC_RUN);
  assign in_stop   = (state_reg == SWC_STOP);
  assign in_settle = (state_reg == SWC_SETTLE);
  assign in_wait   = (state_reg == SWC_WAIT);
  assign run_next  = (state_next == SWC_RUN);

  // Stop wins over wait when the core raises both in one cycle
  assign do_stop     = in_run && stop_instruction;
  assign do_wait     = in_run && wait_instruction && !stop_instruction;
  assign wake_stop   = in_stop && irq_accepted;
  assign wake_wait   = in_wait && irq_accepted;
  assign settle_done = in_settle && tmr_uf;

  // The sixteen-way divider only advances while the oscillator runs
  assign osc_live   = !in_stop;
  assign pre16_run  = route_reg && osc_live;
  assign div16_wrap = (pre16_reg == 4'(`SWC_OSC_PRE_DIV - 1));
  assign div16_tick = pre16_run && div16_wrap;
  assign route_set  = do_stop;
  assign route_clr  = tmr_uf;

  // An edge that enters RUN counts as the first high phase of phi
  assign phase_next = run_next ? phase_reg + 2'd1 : 2'd0;
  // Any edge that leaves RUN already shows phi high, so leaving in the first low cycle cuts that low phase to one cycle
  assign phi_next   = run_next ? (phase_reg < 2'd2) : 1'b1;
  assign osc_next   = (state_next != SWC_STOP);
  assign ovf_next   = tmr_uf;
  // A new stop wins over an overflow since it reloads the whole chain
  assign route_next = route_set ? 1'b1 : (route_clr ? 1'b0 : route_reg);
  assign pre16_next = route_set ? 4'd0 : ((pre16_run && !route_clr) ? pre16_reg + 4'd1 : pre16_reg);

  // Both dividers preload on stop; the timer steps once per prescaler underflow
  // and its own underflow is the overflow that ends settling. With the stop
  // preloads that takes two times 256 times 16 oscillator cycles.
  swc_divider #(.W(PW)) u_prescaler (
    .sys_clk   (sys_clk),
    .arst_n    (arst_n),
    .load      (do_stop),
    .load_val  (PW'(`SWC_PRESCALER_LOAD)),
    .tick      (div16_tick),
    .count     (pre_cnt),
    .underflow (pre_uf)
  );

  // Timer underflow releases the held system clock
  swc_divider #(.W(PW)) u_timer (
    .sys_clk   (sys_clk),
    .arst_n    (arst_n),
    .load      (do_stop),
    .load_val  (PW'(`SWC_TIMER_LOAD)),
    .tick      (pre_uf),
    .count     (tmr_cnt),
    .underflow (tmr_uf)
  );

  // One-hot sequencer; requests outside their own state are ignored,
  // so a stray interrupt in RUN or SETTLE changes nothing
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SWC_RUN: begin
        if (do_stop) begin
          state_next = SWC_STOP;
        end else if (do_wait) begin
          state_next = SWC_WAIT;
        end else begin
          state_next = SWC_RUN;
        end
      end
      SWC_STOP: begin
        if (wake_stop) begin
          state_next = SWC_SETTLE;
        end else begin
          state_next = SWC_STOP;
        end
      end
      SWC_SETTLE: begin
        if (settle_done) begin
          state_next = SWC_RUN;
        end else begin
          state_next = SWC_SETTLE;
        end
      end
      SWC_WAIT: begin
        if (wake_wait) begin
          state_next = SWC_RUN;
        end else begin
          state_next = SWC_WAIT;
        end
      end
      default: state_next = SWC_RUN;
    endcase
  end

  // Core sequencing
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= SWC_RUN;
      phase_reg <= 2'd0;
    end else begin
      state_reg <= state_next;
      phase_reg <= phase_next;
    end
  end

  // Out of reset the core runs, so phi starts high and the oscillator is on
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      phi_reg <= 1'b1;
      osc_reg <= 1'b1;
      ovf_reg <= 1'b0;
    end else begin
      phi_reg <= phi_next;
      osc_reg <= osc_next;
      ovf_reg <= ovf_next;
    end
  end

  // Reset drops the divided-oscillator route just as an overflow does
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      route_reg <= 1'b0;
      pre16_reg <= 4'd0;
    end else begin
      route_reg <= route_next;
      pre16_reg <= pre16_next;
    end
  end

  // Every output comes straight from a flop
  assign phi_out        = phi_reg;
  assign osc_run_en     = osc_reg;
  assign stab_route     = route_reg;
  // Values are unstable while the source switches; reader must avoid that window
  assign prescaler_val  = pre_cnt;
  assign timer_val      = tmr_cnt;
  assign timer_overflow = ovf_reg;
endmodule // swc_clock_control

//--- core/swc_defs.svh
`ifndef SWC_DEFS_SVH
`define SWC_DEFS_SVH

// Oscillator divide ratio feeding the stabilisation prescaler while settling
`define SWC_OSC_PRE_DIV      8'h0010
// Preload values on stop
`define SWC_PRESCALER_LOAD   8'hFF
`define SWC_TIMER_LOAD       8'h01
// System clock is oscillator divided by four
`define SWC_SYS_DIV          2'h3

`endif

//--- core/swc_divider.sv
`include "swc_defs.svh"

// Down-counter that reloads on underflow; divides tick rate by load+1
module swc_divider #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         arst_n,
  // Control
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  input  wire logic         tick,
  // Status
  output logic [W-1:0]      count,
  output logic              underflow
);
  logic [W-1:0] reload_reg;
  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;
  wire          at_zero = (count_reg == '0);

  assign underflow  = tick && at_zero && !load;
  assign count_next = load ? load_val : (tick ? (at_zero ? reload_reg : count_reg - 1'b1) : count_reg);
  assign count      = count_reg;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      count_reg  <= '0;
      reload_reg <= '0;
    end else begin
      count_reg <= count_next;
      if (load) begin
        reload_reg <= load_val;
      end
    end
  end
endmodule // swc_divider

//--- core/swc_pkg.sv
package swc_pkg;
  typedef enum logic [3:0] {
    SWC_RUN    = 4'b0001,
    SWC_STOP   = 4'b0010,
    SWC_SETTLE = 4'b0100,
    SWC_WAIT   = 4'b1000
  } swc_state_t;
endpackage

//--- test/swc_cc_sva.sv
module swc_cc_sva #(
  parameter int PW = 8
) (
  input wire logic          sys_clk, arst_n, stop_instruction, wait_instruction, irq_accepted,
  input wire logic          phi_out, osc_run_en, stab_route, timer_overflow,
  input wire logic [PW-1:0] prescaler_val, timer_val
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // Low phi marks RUN, since every other state holds it high
  property p_stop_entry; stop_instruction && !phi_out && !stab_route |=> !osc_run_en && phi_out && stab_route
    && prescaler_val == 8'hFF && timer_val == 8'h01; endproperty
  a_stop_entry: assert property (p_stop_entry) else $error("stop entry wrong");
  property p_wait_entry; wait_instruction && !stop_instruction && !phi_out && !stab_route
    |=> (phi_out && osc_run_en)[*3]; endproperty
  a_wait_entry: assert property (p_wait_entry) else $error("wait entry wrong");
  property p_hld; !osc_run_en |-> phi_out; endproperty
  a_hld: assert property (p_hld) else $error("phi low while stopped");
  property p_irq; !osc_run_en && irq_accepted |=> osc_run_en; endproperty
  a_irq: assert property (p_irq) else $error("no restart");
  property p_set; stab_route |-> phi_out; endproperty
  a_set: assert property (p_set) else $error("phi low while settling");
  property p_ovf; timer_overflow |-> ##[0:1] !stab_route; endproperty
  a_ovf: assert property (p_ovf) else $error("route kept");
  property p_one; timer_overflow |=> !timer_overflow; endproperty
  a_one: assert property (p_one) else $error("overflow not a pulse");
  property p_div; $fell(phi_out) && !stop_instruction && !wait_instruction |=> !phi_out ##1 phi_out; endproperty
  a_div: assert property (p_div) else $error("phi low phase wrong");
  property p_pre; stab_route && $changed(prescaler_val) |=> ($stable(prescaler_val) || !stab_route)[*8]; endproperty
  a_pre: assert property (p_pre) else $error("prescaler too fast");
  property p_wx; (phi_out && osc_run_en && !stab_route)[*3] ##0 irq_accepted |-> ##[1:3] !phi_out; endproperty
  a_wx: assert property (p_wx) else $error("wait not left");
endmodule // swc_cc_sva

//--- test/swc_clock_control_bench.sv
module swc_clock_control_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 0, arst_n = 0, stop_req = 0, wait_req = 0, irq = 0, phi, oe, rt, ov, ok;
  logic [7:0] pv, tv;
  int fail_count = 0, checks = 0, n;
  // Oscillator well above 1 MHz: the 20 ns period gives 50 MHz
  always #10 sys_clk = ~sys_clk;
  swc_clock_control DUT (.sys_clk, .arst_n, .stop_instruction(stop_req), .wait_instruction(wait_req),
    .irq_accepted(irq),
    .phi_out(phi), .osc_run_en(oe), .stab_route(rt), .prescaler_val(pv), .timer_val(tv), .timer_overflow(ov));
  swc_resonator XO (.sys_clk, .osc_run_en(oe), .settled(ok));
  task chk(string s, logic [7:0] e, logic [7:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask
  task step; @(posedge sys_clk) #1; endtask
  task go(logic s, logic w, logic q);
    @(posedge sys_clk) {stop_req, wait_req, irq} <= {s, w, q};
    @(posedge sys_clk) {stop_req, wait_req, irq} <= 3'b000;
    #1;
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Aligns just after a rising phi edge; a stuck phi ends the run
  task sync;
    for (n = 0; n < 9 && phi !== 1'b0; n++) step;
    for (; n < 9 && phi !== 1'b1; n++) step;
    if (n >= 9) begin
      chk("phi_sync", 1, 0);
      finish_test;
    end
  endtask
  task t_run;
    sync;
    for (int i = 0; i < 8; i++) begin
      chk("phi_run", 8'(i % 4 < 2), phi);
      step;
    end
    $display("run test done");
  endtask
  task t_wait;
    sync; step; go(0, 1, 0);
    for (int i = 0; i < 4; i++) begin
      step;
      chk("phi_wait", 1, phi);
      chk("osc_wait", 1, oe);
    end
    go(0, 0, 1);
    for (n = 0; n < 4 && phi !== 1'b0; n++) step;
    chk("wait_exit", 0, phi);
    if (n >= 4) finish_test;
    $display("wait test done");
  endtask
  task t_stop;
    sync; step; go(1, 0, 0); step;
    chk("phi_stop", 1, phi);
    chk("osc_stop", 0, oe);
    chk("route_on", 1, rt);
    chk("pre_load", 8'hFF, pv);
    chk("tmr_load", 8'h01, tv);
    repeat (8) step;
    chk("pre_frozen", 8'hFF, pv);
    go(0, 0, 1); step;
    chk("osc_on", 1, oe);
    for (n = 0; n < 9000 && ov !== 1'b1; n++) begin
      if (phi !== 1'b1) chk("phi_settle", 1, phi);
      step;
    end
    chk("settle_len", 1, 8'(n > 8170 && n < 8210));
    if (n >= 9000) finish_test;
    chk("xtal_ok", 1, ok);
    step;
    chk("route_off", 0, rt);
    $display("stop test done");
  endtask
  task t_rst;
    sync; step; go(1, 0, 0); step;
    @(posedge sys_clk) arst_n <= 0;
    step;
    chk("rst_route", 0, rt);
    chk("rst_osc", 1, oe);
    @(posedge sys_clk) arst_n <= 1;
    step;
    $display("reset test done");
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    arst_n <= 1;
    t_run; t_wait; t_stop; t_rst; t_run;
    finish_test;
  end
endmodule // swc_clock_control_bench
bind swc_clock_control swc_cc_sva #(.PW(PW)) u_sva (.sys_clk(sys_clk), .arst_n(arst_n),
  .stop_instruction(stop_instruction), .wait_instruction(wait_instruction), .irq_accepted(irq_accepted),
  .phi_out(phi_out), .osc_run_en(osc_run_en), .stab_route(stab_route), .timer_overflow(timer_overflow),
  .prescaler_val(prescaler_val), .timer_val(timer_val));

//--- test/swc_resonator.sv
// Amplitude builds only while enabled and is lost at once on a halt
module swc_resonator #(
  parameter int SETTLE = 4000
) (
  input wire logic sys_clk,
  input wire logic osc_run_en,
  output logic     settled
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  always @(posedge sys_clk) cnt <= osc_run_en ? cnt + 1 : 0;
  assign settled = cnt >= SETTLE;
endmodule // swc_resonator
